// [hdl/cpw_pkg.sv]
// Package of constants and types for the clock select, PLL and watchdog control block.
package cpw_pkg;

   // ------------------------------------------------------------------
   // Bus geometry
   // ------------------------------------------------------------------
   localparam int CPW_ADDR_W = 8;
   localparam int CPW_DATA_W = 32;
   localparam int CPW_REG_W = 8;

   // ------------------------------------------------------------------
   // Register indices; the byte address is four times the index
   // ------------------------------------------------------------------
   localparam logic [5:0] CPW_IDX_CLOCK_SOURCE_SELECT = 6'h39;
   localparam logic [5:0] CPW_IDX_PLL_MODULATION_CONTROL = 6'h3A;
   localparam logic [5:0] CPW_IDX_PERIODIC_TICK_CONTROL = 6'h3B;
   localparam logic [5:0] CPW_IDX_WATCHDOG_CONTROL = 6'h3C;
   localparam logic [5:0] CPW_IDX_WATCHDOG_ARM_RESET = 6'h3F;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] CPW_RST_CLOCK_SOURCE_SELECT = 8'h80;
   localparam logic [7:0] CPW_RST_PLL_MODULATION_CONTROL = 8'h00;
   localparam logic [7:0] CPW_RST_PERIODIC_TICK_CONTROL = 8'h00;
   localparam logic [7:0] CPW_RST_WATCHDOG_CONTROL = 8'h00;

   // ------------------------------------------------------------------
   // Field positions of clock_source_select
   // ------------------------------------------------------------------
   localparam int CPW_CLKS_OSC_SEL = 7;
   localparam int CPW_CLKS_OSC_IN_STOP = 6;
   localparam int CPW_CLKS_TICK_IN_PSTOP = 3;
   localparam int CPW_CLKS_WD_IN_PSTOP = 2;
   localparam int CPW_CLKS_TICK_REF = 1;
   localparam int CPW_CLKS_WD_REF = 0;
   localparam logic [7:0] CPW_CLKS_MASK = 8'hCF;

   // ------------------------------------------------------------------
   // Field positions of pll_modulation_control and watchdog_control
   // ------------------------------------------------------------------
   localparam logic [7:0] CPW_PLL_FM_MASK = 8'h30;
   localparam int CPW_WD_WINDOWED = 7;
   localparam int CPW_WD_HALT_DBG = 6;
   localparam int CPW_WD_WRITE_MASK = 5;
   localparam logic [7:0] CPW_WD_RATE_MASK = 8'h07;
   localparam logic [7:0] CPW_WD_STORE_MASK = 8'hC7;
   localparam logic [7:0] CPW_WD_MASKED_FIELDS = 8'h87;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      CPW_MODE_RUN,
      CPW_MODE_WAIT,
      CPW_MODE_STOP,
      CPW_MODE_PSTOP
   } cpw_mode_e;

   typedef struct packed {
      logic sysclk_from_osc;
      logic osc_enable;
      logic tick_run;
      logic wd_run;
      logic tick_ref_ext;
      logic wd_ref_ext;
      logic [1:0] fm_enable;
   } cpw_clk_cfg_s;

   typedef struct packed {
      logic windowed_watchdog;
      logic watchdog_halt_in_debug;
      logic [2:0] timeout_rate;
   } cpw_wd_cfg_s;

endpackage

// [hdl/cpw_clock_select_pll_watchdog_ctrl.sv]
// Clock source select, PLL modulation, tick and watchdog control registers on an Avalon-MM slave.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// RULE_01: Top clock select bit one picks oscillator for system clocks, zero picks PLL.
// RULE_02: Bit six keeps oscillator running in stop modes; cleared, stop disables it.
// RULE_03: Wait mode behaves exactly as run mode for PLL, tick and watchdog.
// RULE_04: Bits three and two let tick and watchdog run in pseudo-stop.
// RULE_05: Bits one and zero pick internal or external reference for tick, watchdog.
// RULE_06: PLL control bits five and four are modulation enables for VCO output.
// RULE_07: Modulation enable writes land only when unlocked and PLL is selected.
// RULE_08: PLL control bits seven, six and three to zero have no function.
// RULE_09: Watchdog control fields load from flash after system reset release.
// RULE_10: Watchdog clocks from internal or external reference by its choice bit.
// RULE_11: Arm register takes eight bits, reads zero, feeds watchdog service sequence.
// RULE_12: Unused PLL control bits read zero and ignore writes.
module cpw_clock_select_pll_watchdog_ctrl
   import cpw_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // Avalon-MM slave
   input wire logic [CPW_ADDR_W-1:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [3:0] byteenable_i,
   input wire logic [CPW_DATA_W-1:0] writedata_i,
   output logic [CPW_DATA_W-1:0] readdata_o,
   output logic waitrequest_o,
   // Operating state from the power controller
   input wire cpw_mode_e mode_i,
   input wire logic write_protect_lock_i,
   // Flash load of the watchdog settings
   output logic flash_req_o,
   input wire logic flash_valid_i,
   input wire logic [CPW_REG_W-1:0] flash_data_i,
   // Clock tree and timer controls
   output cpw_clk_cfg_s clk_cfg_o,
   output logic [CPW_REG_W-1:0] periodic_tick_cfg_o,
   output cpw_wd_cfg_s wd_cfg_o,
   // Watchdog service sequence
   output logic wd_service_valid_o,
   output logic [CPW_REG_W-1:0] wd_service_data_o
);

   // ------------------------------------------------------------------
   // Types and declarations
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      CPW_LD_IDLE,
      CPW_LD_REQ,
      CPW_LD_DONE
   } cpw_load_e;

   cpw_load_e load_state_reg;
   logic [CPW_REG_W-1:0] clks_reg;
   logic [CPW_REG_W-1:0] pll_reg;
   logic [CPW_REG_W-1:0] tick_reg;
   logic [CPW_REG_W-1:0] wd_reg;
   logic wait_reg;
   logic [CPW_DATA_W-1:0] rdata_reg;
   logic flash_req_reg;
   cpw_clk_cfg_s clk_cfg_reg;
   cpw_clk_cfg_s clk_cfg_next;
   logic svc_valid_reg;
   logic [CPW_REG_W-1:0] svc_data_reg;
   logic [5:0] reg_index;
   logic word_aligned;
   logic wr_fire;
   logic wr_lane;
   logic [CPW_REG_W-1:0] wbyte;
   logic load_busy;
   logic pll_clock_chosen;
   logic stop_like;

   // ------------------------------------------------------------------
   // Address decode helpers
   // ------------------------------------------------------------------
   function automatic logic hit(input logic [5:0] idx, input logic [5:0] target, input logic aligned);
      hit = aligned && (idx == target);
   endfunction

   assign reg_index = address_i[7:2];
   assign word_aligned = (address_i[1:0] == 2'h0);
   assign load_busy = (load_state_reg != CPW_LD_DONE);
   // A write lands only on the edge where waitrequest is sampled low.
   assign wr_fire = write_i && !wait_reg;
   assign wr_lane = byteenable_i[0];
   assign wbyte = writedata_i[7:0];
   assign pll_clock_chosen = !clks_reg[CPW_CLKS_OSC_SEL];
   // Wait is deliberately absent here, so it never changes anything run mode does.
   assign stop_like = (mode_i == CPW_MODE_STOP) || (mode_i == CPW_MODE_PSTOP); // see RULE_03

   // ------------------------------------------------------------------
   // Flash load of watchdog settings after reset
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         load_state_reg <= CPW_LD_IDLE;
         flash_req_reg <= 1'b0;
      end else begin
         case (load_state_reg)
            CPW_LD_IDLE: begin
               load_state_reg <= CPW_LD_REQ;
               flash_req_reg <= 1'b1;
            end
            CPW_LD_REQ: begin
               if (flash_valid_i) begin
                  load_state_reg <= CPW_LD_DONE;
                  flash_req_reg <= 1'b0;
               end
            end
            default: begin
               load_state_reg <= CPW_LD_DONE;
               flash_req_reg <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Bus handshake: one wait cycle, longer while the flash load runs
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         wait_reg <= 1'b1;
      end else if ((read_i || write_i) && wait_reg && !load_busy) begin
         wait_reg <= 1'b0;
      end else begin
         wait_reg <= 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         rdata_reg <= '0;
      end else if (read_i && wait_reg && !load_busy) begin
         rdata_reg <= '0;
         if (hit(reg_index, CPW_IDX_CLOCK_SOURCE_SELECT, word_aligned)) begin
            rdata_reg[7:0] <= clks_reg;
         end else if (hit(reg_index, CPW_IDX_PLL_MODULATION_CONTROL, word_aligned)) begin
            rdata_reg[7:0] <= pll_reg & CPW_PLL_FM_MASK; // see RULE_12
         end else if (hit(reg_index, CPW_IDX_PERIODIC_TICK_CONTROL, word_aligned)) begin
            rdata_reg[7:0] <= tick_reg;
         end else if (hit(reg_index, CPW_IDX_WATCHDOG_CONTROL, word_aligned)) begin
            rdata_reg[7:0] <= wd_reg & CPW_WD_STORE_MASK;
         end
         // The arm register and unmapped words read as zero.
      end
   end

   // ------------------------------------------------------------------
   // Clock source select register
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         clks_reg <= CPW_RST_CLOCK_SOURCE_SELECT;
      end else if (wr_fire && wr_lane && hit(reg_index, CPW_IDX_CLOCK_SOURCE_SELECT, word_aligned)) begin
         clks_reg <= wbyte & CPW_CLKS_MASK;
      end
   end

   // ------------------------------------------------------------------
   // PLL modulation control register
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         pll_reg <= CPW_RST_PLL_MODULATION_CONTROL;
      end else if (wr_fire && wr_lane && hit(reg_index, CPW_IDX_PLL_MODULATION_CONTROL, word_aligned)) begin
         if (!write_protect_lock_i && pll_clock_chosen) begin // see RULE_07
            pll_reg <= wbyte & CPW_PLL_FM_MASK; // see RULE_08
         end
      end
   end

   // ------------------------------------------------------------------
   // Periodic tick control register
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         tick_reg <= CPW_RST_PERIODIC_TICK_CONTROL;
      end else if (wr_fire && wr_lane && hit(reg_index, CPW_IDX_PERIODIC_TICK_CONTROL, word_aligned)) begin
         tick_reg <= wbyte;
      end
   end

   // ------------------------------------------------------------------
   // Watchdog control register
   // ------------------------------------------------------------------
   // The write mask bit is a per-write qualifier and is never stored, so it reads zero.
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         wd_reg <= CPW_RST_WATCHDOG_CONTROL;
      end else if (load_state_reg == CPW_LD_REQ && flash_valid_i) begin
         wd_reg <= flash_data_i & CPW_WD_STORE_MASK; // see RULE_09
      end else if (wr_fire && wr_lane && hit(reg_index, CPW_IDX_WATCHDOG_CONTROL, word_aligned)) begin
         wd_reg[CPW_WD_HALT_DBG] <= wbyte[CPW_WD_HALT_DBG];
         if (!wbyte[CPW_WD_WRITE_MASK]) begin
            wd_reg[CPW_WD_WINDOWED] <= wbyte[CPW_WD_WINDOWED];
            wd_reg[2:0] <= wbyte[2:0];
         end
      end
   end

   // ------------------------------------------------------------------
   // Watchdog arm and service strobe
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         svc_valid_reg <= 1'b0;
         svc_data_reg <= 8'h00;
      end else if (wr_fire && wr_lane && hit(reg_index, CPW_IDX_WATCHDOG_ARM_RESET, word_aligned)) begin
         svc_valid_reg <= 1'b1; // see RULE_11
         svc_data_reg <= wbyte;
      end else begin
         svc_valid_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Clock tree controls
   // ------------------------------------------------------------------
   always_comb begin
      clk_cfg_next = '0;
      clk_cfg_next.sysclk_from_osc = clks_reg[CPW_CLKS_OSC_SEL]; // see RULE_01
      clk_cfg_next.osc_enable = !(stop_like && !clks_reg[CPW_CLKS_OSC_IN_STOP]); // see RULE_02
      clk_cfg_next.tick_run = 1'b1;
      clk_cfg_next.wd_run = 1'b1;
      if (mode_i == CPW_MODE_PSTOP) begin
         clk_cfg_next.tick_run = clks_reg[CPW_CLKS_TICK_IN_PSTOP]; // see RULE_04
         clk_cfg_next.wd_run = clks_reg[CPW_CLKS_WD_IN_PSTOP]; // see RULE_04
      end else if (mode_i == CPW_MODE_STOP) begin
         clk_cfg_next.tick_run = 1'b0;
         clk_cfg_next.wd_run = 1'b0;
      end
      clk_cfg_next.tick_ref_ext = clks_reg[CPW_CLKS_TICK_REF]; // see RULE_05
      clk_cfg_next.wd_ref_ext = clks_reg[CPW_CLKS_WD_REF]; // see RULE_10
      clk_cfg_next.fm_enable = pll_reg[5:4]; // see RULE_06
   end

   // Registering the controls costs one cycle but keeps glitches off the clock tree.
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         clk_cfg_reg <= '0;
      end else begin
         clk_cfg_reg <= clk_cfg_next;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign readdata_o = rdata_reg;
   assign waitrequest_o = wait_reg;
   assign flash_req_o = flash_req_reg;
   assign clk_cfg_o = clk_cfg_reg;
   assign periodic_tick_cfg_o = tick_reg;
   assign wd_cfg_o.windowed_watchdog = wd_reg[CPW_WD_WINDOWED];
   assign wd_cfg_o.watchdog_halt_in_debug = wd_reg[CPW_WD_HALT_DBG];
   assign wd_cfg_o.timeout_rate = wd_reg[2:0];
   assign wd_service_valid_o = svc_valid_reg;
   assign wd_service_data_o = svc_data_reg;

endmodule

`default_nettype wire

// [tb/cpw_ctrl_sva.sv]
// Checker of the clock select, PLL and watchdog control block seen at its ports.
`timescale 1ns/100ps
`default_nettype none
module cpw_ctrl_sva
   import cpw_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // Register bus
   input wire logic [CPW_ADDR_W-1:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [3:0] byteenable_i,
   input wire logic [CPW_DATA_W-1:0] writedata_i,
   input wire logic [CPW_DATA_W-1:0] readdata_o,
   input wire logic waitrequest_o,
   // Operating state
   input wire cpw_mode_e mode_i,
   input wire logic write_protect_lock_i,
   // Flash load
   input wire logic flash_req_o,
   input wire logic flash_valid_i,
   input wire logic [CPW_REG_W-1:0] flash_data_i,
   // Controls and service
   input wire cpw_clk_cfg_s clk_cfg_o,
   input wire cpw_wd_cfg_s wd_cfg_o,
   input wire logic wd_service_valid_o,
   input wire logic [CPW_REG_W-1:0] wd_service_data_o
);
   // ------------------------------------------------------------------
   // Accepted transfers
   // ------------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   logic wr_ok;
   logic rd_ok;
   assign wr_ok = write_i && !waitrequest_o && byteenable_i[0];
   assign rd_ok = read_i && !waitrequest_o;

   a_clock_source_follow: assert property (wr_ok && address_i == 8'hE4 |-> ##2
      {clk_cfg_o.sysclk_from_osc, clk_cfg_o.tick_ref_ext, clk_cfg_o.wd_ref_ext} ==
      {$past(writedata_i[7], 2), $past(writedata_i[1:0], 2)}) else $error("clock source fields did not follow write");
   a_wait_like_run: assert property (rst_b_i && mode_i inside {CPW_MODE_RUN, CPW_MODE_WAIT} |=>
      clk_cfg_o.osc_enable && clk_cfg_o.tick_run && clk_cfg_o.wd_run) else $error("run or wait altered the clocks");
   a_stop_halts_timers: assert property (rst_b_i && mode_i == CPW_MODE_STOP |=>
      !clk_cfg_o.tick_run && !clk_cfg_o.wd_run) else $error("timers kept running in stop");
   a_fm_write_locked: assert property (wr_ok && address_i == 8'hE8 &&
      (write_protect_lock_i || clk_cfg_o.sysclk_from_osc) |-> ##2
      clk_cfg_o.fm_enable == $past(clk_cfg_o.fm_enable, 2)) else $error("locked modulation write landed");
   a_pll_unused_zero: assert property (rd_ok && address_i == 8'hE8 |-> (readdata_o & 32'hFFFFFFCF) == 32'h0)
      else $error("unused PLL bits read nonzero");
   a_flash_held: assert property (flash_req_o && !flash_valid_i |=> flash_req_o)
      else $error("flash request dropped early");
   a_flash_taken: assert property (flash_req_o && flash_valid_i |=> !flash_req_o &&
      wd_cfg_o == {$past(flash_data_i[7:6]), $past(flash_data_i[2:0])}) else $error("flash word not loaded");
   a_service_pulse: assert property (wr_ok && address_i == 8'hFC |=>
      wd_service_valid_o && wd_service_data_o == $past(writedata_i[7:0]) ##1 !wd_service_valid_o)
      else $error("service strobe wrong");
   a_arm_reads_zero: assert property (rd_ok && address_i == 8'hFC |-> readdata_o == 32'h0)
      else $error("arm register read nonzero");

   c_flash_load: cover property (flash_req_o && flash_valid_i);
   c_fm_write: cover property (wr_ok && address_i == 8'hE8 && !write_protect_lock_i);
   c_pstop: cover property (mode_i == CPW_MODE_PSTOP ##1 clk_cfg_o.tick_run);
endmodule
bind cpw_clock_select_pll_watchdog_ctrl cpw_ctrl_sva chk_u (.core_clk_i, .rst_b_i, .address_i, .read_i, .write_i,
   .byteenable_i, .writedata_i, .readdata_o, .waitrequest_o, .mode_i, .write_protect_lock_i, .flash_req_o,
   .flash_valid_i, .flash_data_i, .clk_cfg_o, .wd_cfg_o, .wd_service_valid_o, .wd_service_data_o);
`default_nettype wire

// [tb/cpw_clock_select_pll_watchdog_ctrl_tb_top.sv]
// Register-level testbench of the clock select, PLL and watchdog control block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cpw_clock_select_pll_watchdog_ctrl_tb_top
   import cpw_pkg::*;
;
   // ------------------------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------------------------
   logic core_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [7:0] address_i = 8'h00;
   logic read_i = 1'b0;
   logic write_i = 1'b0;
   logic [3:0] byteenable_i = 4'hF;
   logic [31:0] writedata_i = 32'h0;
   logic [31:0] readdata_o;
   logic waitrequest_o;
   cpw_mode_e mode_i = CPW_MODE_RUN;
   logic write_protect_lock_i = 1'b1;
   logic flash_req_o;
   logic flash_valid_i = 1'b0;
   logic [7:0] flash_data_i = 8'h00;
   cpw_clk_cfg_s clk_cfg_o;
   logic [7:0] periodic_tick_cfg_o;
   cpw_wd_cfg_s wd_cfg_o;
   logic wd_service_valid_o;
   logic [7:0] wd_service_data_o;
   int err_count = 0;
   int samples_checked = 0;
   logic [31:0] rd;
   logic [7:0] clks;
   cpw_mode_e m;

   always #2 core_clk_i = ~core_clk_i;

   cpw_clock_select_pll_watchdog_ctrl dut_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .address_i(address_i),
      .read_i(read_i), .write_i(write_i), .byteenable_i(byteenable_i), .writedata_i(writedata_i),
      .readdata_o(readdata_o),
      .waitrequest_o(waitrequest_o), .mode_i(mode_i), .write_protect_lock_i(write_protect_lock_i),
      .flash_req_o(flash_req_o), .flash_valid_i(flash_valid_i), .flash_data_i(flash_data_i), .clk_cfg_o(clk_cfg_o),
      .periodic_tick_cfg_o(periodic_tick_cfg_o), .wd_cfg_o(wd_cfg_o), .wd_service_valid_o(wd_service_valid_o),
      .wd_service_data_o(wd_service_data_o));

   // ------------------------------------------------------------------
   // Bus tasks; the request is held until waitrequest is seen low
   // ------------------------------------------------------------------
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      address_i <= a;
      writedata_i <= {24'h0, d};
      write_i <= 1'b1;
      do @(posedge core_clk_i); while (waitrequest_o !== 1'b0);
      write_i <= 1'b0;
   endtask

   task automatic bus_rd(input logic [7:0] a, output logic [31:0] q);
      @(posedge core_clk_i);
      address_i <= a;
      read_i <= 1'b1;
      do @(posedge core_clk_i); while (waitrequest_o !== 1'b0);
      q = readdata_o;
      read_i <= 1'b0;
   endtask

   task automatic close_out();
      $display("checked %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Reset, then hand over the flash word in the cycle after the request is seen.
   task automatic reset_and_load(input logic [7:0] d);
      rst_b_i <= 1'b0;
      repeat (12) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      do @(posedge core_clk_i); while (flash_req_o !== 1'b1);
      flash_valid_i <= 1'b1;
      flash_data_i <= d;
      @(posedge core_clk_i);
      flash_valid_i <= 1'b0;
      @(posedge core_clk_i);
   endtask

   // A hung handshake would otherwise stall the run forever.
   initial begin
      repeat (20000) @(posedge core_clk_i);
      err_count++;
      close_out();
   end

   // ------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------
   initial begin
      reset_and_load(8'hFF);
      `CHK(wd_cfg_o, 5'h1F)
      bus_rd(8'hF0, rd); `CHK(rd, 32'hC7)
      bus_rd(8'hE4, rd); `CHK(rd, 32'h80)
      `CHK(clk_cfg_o.sysclk_from_osc, 1'b1)
      bus_rd(8'hEC, rd); `CHK(rd, 32'h00)
      write_protect_lock_i <= 1'b0;
      bus_wr(8'hE8, 8'hFF);
      bus_rd(8'hE8, rd); `CHK(rd, 32'h00)
      bus_wr(8'hE4, 8'h7F);
      bus_rd(8'hE4, rd); `CHK(rd, 32'h4F)
      `CHK({clk_cfg_o.sysclk_from_osc, clk_cfg_o.tick_ref_ext, clk_cfg_o.wd_ref_ext}, 3'b011)
      write_protect_lock_i <= 1'b1;
      bus_wr(8'hE8, 8'hFF);
      bus_rd(8'hE8, rd); `CHK(rd, 32'h00)
      write_protect_lock_i <= 1'b0;
      bus_wr(8'hE8, 8'hFF);
      bus_rd(8'hE8, rd); `CHK(rd, 32'h30)
      `CHK(clk_cfg_o.fm_enable, 2'b11)
      for (int i = 0; i < 8; i++) begin
         clks = (i < 4) ? 8'h4B : 8'h04;
         m = cpw_mode_e'(i % 4);
         bus_wr(8'hE4, clks);
         mode_i <= m;
         repeat (3) @(posedge core_clk_i);
         `CHK(clk_cfg_o.osc_enable, (m inside {CPW_MODE_RUN, CPW_MODE_WAIT}) || clks[6])
         `CHK(clk_cfg_o.tick_run, (m == CPW_MODE_PSTOP) ? clks[3] : (m != CPW_MODE_STOP))
         `CHK(clk_cfg_o.wd_run, (m == CPW_MODE_PSTOP) ? clks[2] : (m != CPW_MODE_STOP))
      end
      mode_i <= CPW_MODE_RUN;
      bus_wr(8'hEC, 8'hA5);
      bus_rd(8'hEC, rd); `CHK(rd, 32'hA5)
      `CHK(periodic_tick_cfg_o, 8'hA5)
      byteenable_i <= 4'hE;
      bus_wr(8'hEC, 8'h3C);
      byteenable_i <= 4'hF;
      bus_rd(8'hEC, rd); `CHK(rd, 32'hA5)
      bus_wr(8'hF0, 8'h20);
      bus_rd(8'hF0, rd); `CHK(rd, 32'h87)
      bus_wr(8'hF0, 8'h42);
      bus_rd(8'hF0, rd); `CHK(rd, 32'h42)
      `CHK(wd_cfg_o, 5'h0A)
      bus_wr(8'hFC, 8'h5A);
      @(posedge core_clk_i);
      `CHK({wd_service_valid_o, wd_service_data_o}, 9'h15A)
      @(posedge core_clk_i);
      `CHK(wd_service_valid_o, 1'b0)
      bus_rd(8'hFC, rd); `CHK(rd, 32'h00)
      bus_rd(8'h00, rd); `CHK(rd, 32'h00)
      reset_and_load(8'h05);
      `CHK(wd_cfg_o, 5'h05)
      bus_rd(8'hF0, rd); `CHK(rd, 32'h05)
      bus_rd(8'hE4, rd); `CHK(rd, 32'h80)
      `CHK(clk_cfg_o.sysclk_from_osc, 1'b1)
      bus_rd(8'hE8, rd); `CHK(rd, 32'h00)
      bus_rd(8'hEC, rd); `CHK(rd, 32'h00)
      close_out();
   end
endmodule
`default_nettype wire
